// *** bench/lnb_ctrl_regs_asserts.sv ***
// checker: port-level properties of the LNB control register bank
`timescale 1ns/1ps
module lnb_ctrl_regs_asserts
  import lnb_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_link_in,
  input wire logic sda_oe_out,
  input wire logic power_ok_in,
  input wire logic ch1_tone_modulation_input_in,
  input wire logic ch2_tone_modulation_input_in,
  input wire lnb_chan_t ch1_out,
  input wire lnb_chan_t ch2_out,
  input wire logic limiter_static_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic scl_q;
  logic [3:0] idle_cnt;
  // cycles since the last SCL edge, saturating
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_q <= 1'b1;
      idle_cnt <= 4'h0;
    end else begin
      scl_q <= scl_link_in;
      idle_cnt <= (scl_q != scl_link_in) ? 4'h0 : idle_cnt + {3'h0, idle_cnt != 4'hF};
    end
  end
  sequence s_down; (!power_ok_in)[*6]; endsequence
  sequence s_gate1; (ch1_tone_modulation_input_in && ch1_out.boost_en)[*5]; endsequence
  sequence s_gate2; (ch2_tone_modulation_input_in && ch2_out.boost_en)[*5]; endsequence
  property p_rst_clear;
    $fell(sys_rst_in) |-> ch1_out == 6'h00 && ch2_out == 6'h00 && !limiter_static_out;
  endproperty
  property p_pwr_clear;
    s_down |-> ch1_out == 6'h00 && ch2_out == 6'h00 && !limiter_static_out;
  endproperty
  property p_pwr_nack; s_down |-> !$rose(sda_oe_out); endproperty
  property p_en1; ch1_out.boost_en == ch1_out.linreg_en; endproperty
  property p_en2; ch2_out.boost_en == ch2_out.linreg_en; endproperty
  property p_off;
    !(ch1_out.tone && !ch1_out.boost_en) && !(ch2_out.tone && !ch2_out.boost_en);
  endproperty
  property p_tone1; s_gate1 |-> ch1_out.tone; endproperty
  property p_tone2; s_gate2 |-> ch2_out.tone; endproperty
  // while power_ok_in is high, outputs other than tone only move as a result of link traffic
  property p_quiet;
    $changed({ch1_out.boost_en, ch1_out.level, ch1_out.current_high, ch2_out.boost_en,
      ch2_out.level, ch2_out.current_high, limiter_static_out}) && power_ok_in
      |-> idle_cnt < 4'hF;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear after reset");
  a_pwr_clear: assert property (p_pwr_clear) else $error("outputs kept at power loss");
  a_pwr_nack: assert property (p_pwr_nack) else $error("ack given without power");
  a_en1: assert property (p_en1) else $error("channel one enables differ");
  a_en2: assert property (p_en2) else $error("channel two enables differ");
  a_off: assert property (p_off) else $error("tone on a disabled channel");
  a_tone1: assert property (p_tone1) else $error("channel one tone ignores pin");
  a_tone2: assert property (p_tone2) else $error("channel two tone ignores pin");
  a_quiet: assert property (p_quiet) else $error("outputs moved without traffic");
endmodule

bind lnb_ctrl_regs lnb_ctrl_regs_asserts chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .scl_link_in(scl_link_in), .sda_oe_out(sda_oe_out), .power_ok_in(power_ok_in),
  .ch1_tone_modulation_input_in(ch1_tone_modulation_input_in),
  .ch2_tone_modulation_input_in(ch2_tone_modulation_input_in),
  .ch1_out(ch1_out), .ch2_out(ch2_out), .limiter_static_out(limiter_static_out));

// *** bench/lnb_i2c_master.sv ***
// partner: I2C master driving SCL and SDA towards the register bank
`timescale 1ns/1ps
module lnb_i2c_master #(
  parameter int HALF = 613
) (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // eight bits and the ack slot; data moves well clear of the SCL fall
  task automatic put(input logic [8:0] v, output logic [8:0] s);
    for (int i = 8; i >= 0; i--) begin
      #(HALF / 3);
      sda_out = v[i];
      #HALF;
      scl_out = 1'b1;
      #HALF;
      s[i] = sda_in;
      scl_out = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] d,
      output logic [8:0] s1, output logic [8:0] s2, output logic [8:0] s3);
    s3 = 9'h1FF;
    sda_out = 1'b0;
    #HALF;
    scl_out = 1'b0;
    put({a, 1'b1}, s1);
    if (a[0]) begin
      put(9'h1FE, s2);
      put(9'h1FF, s3);
    end else begin
      put({d, 1'b1}, s2);
    end
    #(HALF / 3);
    sda_out = 1'b0;
    #HALF;
    scl_out = 1'b1;
    #HALF;
    sda_out = 1'b1;
    #HALF;
  endtask
  // an ignored address byte, a repeated start, then a full write body
  task automatic rs_frame(input logic [7:0] a0, input logic [7:0] a, input logic [7:0] d,
      output logic [8:0] s0, output logic [8:0] s1, output logic [8:0] s2);
    sda_out = 1'b0;
    #HALF;
    scl_out = 1'b0;
    put({a0, 1'b1}, s0);
    #(HALF / 3);
    sda_out = 1'b1;
    #HALF;
    scl_out = 1'b1;
    #HALF;
    sda_out = 1'b0;
    #HALF;
    scl_out = 1'b0;
    put({a, 1'b1}, s1);
    put({d, 1'b1}, s2);
    #(HALF / 3);
    sda_out = 1'b0;
    #HALF;
    scl_out = 1'b1;
    #HALF;
    sda_out = 1'b1;
    #HALF;
  endtask
endmodule

// *** bench/test_dual_lnb_control_registers.sv ***
// testbench: register bank driven through the I2C master model
`timescale 1ns/1ps
module test_dual_lnb_control_registers
  import lnb_pkg::*;
;
  typedef struct packed {logic [7:0] d; lnb_chan_t e1; lnb_chan_t e2; logic lim;} lnb_row_t;
  localparam lnb_row_t ROWS [8] = '{'{8'h7E, 6'h3F, 6'h00, 1'b1}, '{8'hFD, 6'h3F, 6'h3F, 1'b1},
    '{8'h0A, 6'h38, 6'h3F, 1'b0}, '{8'h06, 6'h34, 6'h3F, 1'b0}, '{8'h02, 6'h30, 6'h3F, 1'b0},
    '{8'h9C, 6'h30, 6'h3C, 1'b0}, '{8'h7C, 6'h0D, 6'h3C, 1'b1}, '{8'hC8, 6'h0D, 6'h05, 1'b1}};
  logic clk_in, sys_rst_in, power_ok, addr_sel, tone1, tone2, ovl1, ovl2, otemp;
  logic scl, m_sda, sda_w, oe, sda_o, lim;
  lnb_chan_t ch1, ch2;
  logic [8:0] s1, s2, s3;
  int fails, compares, cyc;
  // wired-AND with the bus pull-up
  assign sda_w = m_sda & (oe ? sda_o : 1'b1);
  lnb_ctrl_regs dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_link_in(scl),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(oe), .power_ok_in(power_ok),
    .addr_sel_in(addr_sel), .ch1_tone_modulation_input_in(tone1),
    .ch2_tone_modulation_input_in(tone2), .ch1_overload_in(ovl1), .ch2_overload_in(ovl2),
    .over_temperature_in(otemp), .ch1_out(ch1), .ch2_out(ch2), .limiter_static_out(lim));
  lnb_i2c_master mst_u (.sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));
  always #50 clk_in = ~clk_in;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic outs(input lnb_chan_t e1, input lnb_chan_t e2, input logic el);
    chk("ch1", {2'h0, e1}, {2'h0, ch1});
    chk("ch2", {2'h0, e2}, {2'h0, ch2});
    chk("limiter", {7'h0, el}, {7'h0, lim});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mst_u.frame(a, d, s1, s2, s3);
    step(2);
  endtask
  task automatic final_report;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    clk_in = 1'b0;
    sys_rst_in = 1'b1;
    {power_ok, addr_sel, tone1, tone2, ovl1, ovl2, otemp} = 7'h40;
    step(10);
    sys_rst_in = 1'b0;
    step(3);
    outs(6'h00, 6'h00, 1'b0);
    chk("sda_level", 8'h00, {7'h0, sda_o});
    for (int i = 0; i < 8; i++) begin
      wr(8'h10, ROWS[i].d);
      chk("ack", 8'h00, {7'h0, s1[0] | s2[0]});
      outs(ROWS[i].e1, ROWS[i].e2, ROWS[i].lim);
    end
    ovl1 = 1'b1;
    otemp = 1'b1;
    step(3);
    wr(8'h11, 8'h00);
    chk("rd_one", 8'h7D, s2[8:1]);
    chk("rd_two", 8'hCA, s3[8:1]);
    {ovl1, otemp} = 2'h0;
    wr(8'h10, 8'h02);
    wr(8'h10, 8'h84);
    {tone1, tone2} = 2'h3;
    step(6);
    outs(6'h32, 6'h32, 1'b0);
    {tone1, tone2} = 2'h0;
    step(6);
    outs(6'h30, 6'h30, 1'b0);
    wr(8'h12, 8'h00);
    chk("nack", 8'h01, {7'h0, s1[0]});
    outs(6'h30, 6'h30, 1'b0);
    addr_sel = 1'b1;
    step(3);
    wr(8'h12, 8'h00);
    outs(6'h00, 6'h30, 1'b0);
    power_ok = 1'b0;
    step(8);
    outs(6'h00, 6'h00, 1'b0);
    wr(8'h12, 8'h02);
    chk("nack", 8'h01, {7'h0, s1[0]});
    outs(6'h00, 6'h00, 1'b0);
    power_ok = 1'b1;
    step(3);
    wr(8'h12, 8'h02);
    outs(6'h30, 6'h00, 1'b0);
    mst_u.rs_frame(8'h10, 8'h12, 8'h84, s3, s1, s2);
    step(2);
    chk("rs_nack", 8'h01, {7'h0, s3[0]});
    chk("rs_ack", 8'h00, {7'h0, s1[0] | s2[0]});
    outs(6'h30, 6'h30, 1'b0);
    sys_rst_in = 1'b1;
    step(2);
    sys_rst_in = 1'b0;
    step(2);
    outs(6'h00, 6'h00, 1'b0);
    final_report;
  end
endmodule

// *** hw/lnb_ctrl_regs.sv ***
// design: I2C slave with two control/status registers for a dual LNB supply
`timescale 1ns/1ps

module lnb_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

module lnb_ctrl_regs
  import lnb_pkg::*;
(
  // system clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // I2C link, SCL is the link clock
  input wire logic scl_link_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // status and strap pins
  input wire logic power_ok_in,
  input wire logic addr_sel_in,
  input wire logic ch1_tone_modulation_input_in,
  input wire logic ch2_tone_modulation_input_in,
  input wire logic ch1_overload_in,
  input wire logic ch2_overload_in,
  input wire logic over_temperature_in,
  // channel controls
  output lnb_chan_t ch1_out,
  output lnb_chan_t ch2_out,
  output logic limiter_static_out
);
  lnb_pins_t pins_raw;
  lnb_pins_t pins_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic start_det;
  logic stop_det;
  lnb_frame_st_t frame_reg;
  logic frame_hold_reg;
  lnb_cfg_t cfg_reg;
  logic link_rst;
  lnb_link_st_t lstate_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic rw_reg;
  logic byte_sel_reg;
  logic [7:0] rd_byte;
  logic sda_oe_reg;
  logic [7:0] wr_word_reg;
  logic wr_tog_reg;
  logic tog_meta_reg;
  logic tog_sync_reg;
  logic tog_seen_reg;
  logic [7:0] reg1_reg;
  logic [7:0] reg2_reg;
  logic [7:0] image1;
  logic [7:0] image2;
  logic sda_drive_reg;

  assign pins_raw = '{
    scl: scl_link_in,
    sda: sda_in,
    power_ok: power_ok_in,
    addr_sel: addr_sel_in,
    ch1_tone_mod: ch1_tone_modulation_input_in,
    ch2_tone_mod: ch2_tone_modulation_input_in,
    ch1_overload: ch1_overload_in,
    ch2_overload: ch2_overload_in,
    over_temp: over_temperature_in
  };

  lnb_sync2 #(
    .WIDTH($bits(lnb_pins_t))
  ) u_pin_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .d_in(pins_raw),
    .q_out(pins_s)
  );

  // ---------------- system clock domain: frame tracking ----------------

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= pins_s.scl;
      sda_prev_reg <= pins_s.sda;
    end
  end

  // sda edges while scl stays high mark frame boundaries
  assign start_det = pins_s.scl & scl_prev_reg & sda_prev_reg & ~pins_s.sda;
  assign stop_det = pins_s.scl & scl_prev_reg & ~sda_prev_reg & pins_s.sda;

  // the link logic is held in reset outside frames; release happens while scl
  // is low after the start, so no scl edge races the release
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      frame_reg <= FR_IDLE;
      frame_hold_reg <= 1'b1;
    end else begin
      case (frame_reg)
        FR_IDLE: begin
          frame_hold_reg <= 1'b1;
          if (start_det) begin
            frame_reg <= FR_ARMED;
          end
        end
        FR_ARMED: begin
          if (stop_det) begin
            frame_reg <= FR_IDLE;
          end else if (!pins_s.scl) begin
            frame_reg <= FR_BUSY;
            frame_hold_reg <= 1'b0;
          end
        end
        FR_BUSY: begin
          if (stop_det) begin
            frame_reg <= FR_IDLE;
            frame_hold_reg <= 1'b1;
          end else if (start_det) begin
            frame_reg <= FR_ARMED;
            frame_hold_reg <= 1'b1;
          end
        end
        default: begin
          frame_reg <= FR_IDLE;
          frame_hold_reg <= 1'b1;
        end
      endcase
    end
  end

  // readback images: writable bits as stored, flags live from the pins
  always_comb begin
    image1 = reg1_reg;
    image1[SEL_BIT] = 1'b0;
    image1[R1_OVERLOAD] = pins_s.ch1_overload;
    image2 = reg2_reg;
    image2[SEL_BIT] = 1'b1;
    image2[R2_OVERTEMP] = pins_s.over_temp;
    image2[R2_OVERLOAD] = pins_s.ch2_overload;
  end

  // snapshot is taken up to the frame's first clock low, then frozen; the
  // trade is that a flag change mid-frame shows in the next read
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_reg <= '0;
    end else if (frame_hold_reg) begin
      cfg_reg <= '{
        power_ok: pins_s.power_ok,
        addr_sel: pins_s.addr_sel,
        image1: image1,
        image2: image2
      };
    end
  end

  // ---------------- link clock domain ----------------

  assign link_rst = sys_rst_in | frame_hold_reg;
  assign shift_next = {shift_reg[6:0], sda_in};
  assign rd_byte = byte_sel_reg ? cfg_reg.image2 : cfg_reg.image1;

  always_ff @(posedge scl_link_in or posedge link_rst) begin
    if (link_rst) begin
      lstate_reg <= LS_ADDR;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      byte_sel_reg <= 1'b0;
    end else begin
      case (lstate_reg)
        LS_ADDR: begin
          shift_reg <= shift_next;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == BIT_LAST) begin
            rw_reg <= sda_in;
            if (shift_next[7:1] == {SLAVE_ADDR_HI, cfg_reg.addr_sel} && cfg_reg.power_ok) begin
              lstate_reg <= LS_ADDR_ACK;
            end else begin
              lstate_reg <= LS_IGNORE;
            end
          end
        end
        LS_ADDR_ACK: begin
          bit_cnt_reg <= 3'h0;
          lstate_reg <= rw_reg ? LS_RDATA : LS_WDATA;
        end
        LS_WDATA: begin
          shift_reg <= shift_next;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == BIT_LAST) begin
            lstate_reg <= LS_WACK;
          end
        end
        LS_WACK: begin
          lstate_reg <= LS_IGNORE;
        end
        LS_RDATA: begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == BIT_LAST) begin
            lstate_reg <= LS_RACK;
          end
        end
        LS_RACK: begin
          // master acknowledge asks for the other register next
          bit_cnt_reg <= 3'h0;
          if (!sda_in) begin
            byte_sel_reg <= ~byte_sel_reg;
            lstate_reg <= LS_RDATA;
          end else begin
            lstate_reg <= LS_IGNORE;
          end
        end
        LS_IGNORE: begin
          lstate_reg <= LS_IGNORE;
        end
        default: begin
          lstate_reg <= LS_IGNORE;
        end
      endcase
    end
  end

  // the written byte is handed over by toggle; word and toggle survive the
  // frame reset so a stop right after the byte cannot lose it
  always_ff @(posedge scl_link_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_word_reg <= 8'h00;
      wr_tog_reg <= 1'b0;
    end else if (!frame_hold_reg && lstate_reg == LS_WDATA && bit_cnt_reg == BIT_LAST) begin
      wr_word_reg <= shift_next;
      wr_tog_reg <= ~wr_tog_reg;
    end
  end

  // sda changes only while scl is low; acks never depend on the master
  // sampling them, so a master that skips the check still works
  always_ff @(negedge scl_link_in or posedge link_rst) begin
    if (link_rst) begin
      sda_oe_reg <= 1'b0;
    end else begin
      case (lstate_reg)
        LS_ADDR_ACK: sda_oe_reg <= 1'b1;
        LS_WACK: sda_oe_reg <= 1'b1;
        LS_RDATA: sda_oe_reg <= ~rd_byte[BIT_LAST - bit_cnt_reg];
        default: sda_oe_reg <= 1'b0;
      endcase
    end
  end

  assign sda_oe_out = sda_oe_reg;

  // ---------------- system clock domain: registers ----------------

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      tog_seen_reg <= 1'b0;
    end else begin
      tog_meta_reg <= wr_tog_reg;
      tog_sync_reg <= tog_meta_reg;
      tog_seen_reg <= tog_sync_reg;
    end
  end

  // flag positions are never stored; they are overlaid on readback
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg1_reg <= REG_RESET;
      reg2_reg <= REG_RESET;
    end else if (!pins_s.power_ok) begin
      reg1_reg <= REG_RESET;
      reg2_reg <= REG_RESET;
    end else if (tog_sync_reg != tog_seen_reg) begin
      if (!wr_word_reg[SEL_BIT]) begin
        reg1_reg[R1_LIMITER:R1_ENABLE] <= wr_word_reg[R1_LIMITER:R1_ENABLE];
      end else begin
        reg2_reg[R2_CURRENT:R2_ENABLE] <= wr_word_reg[R2_CURRENT:R2_ENABLE];
      end
    end
  end

  // channel one; a disabled channel has boost, linear and tone off
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ch1_out <= '0;
    end else begin
      ch1_out.boost_en <= reg1_reg[R1_ENABLE];
      ch1_out.linreg_en <= reg1_reg[R1_ENABLE];
      ch1_out.level <= {reg1_reg[R1_COMP], reg1_reg[R1_HIGHV]};
      ch1_out.tone <= reg1_reg[R1_ENABLE]
        & (reg1_reg[R1_TONE] | pins_s.ch1_tone_mod);
      ch1_out.current_high <= reg1_reg[R1_CURRENT];
    end
  end

  // channel two, same shape as channel one
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ch2_out <= '0;
    end else begin
      ch2_out.boost_en <= reg2_reg[R2_ENABLE];
      ch2_out.linreg_en <= reg2_reg[R2_ENABLE];
      ch2_out.level <= {reg2_reg[R2_COMP], reg2_reg[R2_HIGHV]};
      ch2_out.tone <= reg2_reg[R2_ENABLE]
        & (reg2_reg[R2_TONE] | pins_s.ch2_tone_mod);
      ch2_out.current_high <= reg2_reg[R2_CURRENT];
    end
  end

  // limiter mode is shared by both channels
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      limiter_static_out <= 1'b0;
      sda_drive_reg <= 1'b0;
    end else begin
      limiter_static_out <= reg1_reg[R1_LIMITER];
      sda_drive_reg <= 1'b0;
    end
  end

  // open drain: the driven level is always low
  assign sda_out = sda_drive_reg;
endmodule

// *** hw/lnb_pkg.sv ***
// package: constants and types for the dual LNB supply control register bank
// Overview of operation
// - frame: start, address, one data byte (reads run on while the master acks), stop
// - address MSB first, LSB one means read
// - write direction stores data byte in register
// - power-on reset clears both registers
// - register one: selector, limiter, channel-one fields
// - register two: selector, channel-two fields, flags
// - compensation and high-voltage pick output level
// - tone force overrides tone modulation pin
// - limiter bit one static, zero dynamic
// - enable zero disables boost and linear
// - current level bit picks limit band
// - read returns written bits plus live flags
// - no acknowledge while power-good is low
package lnb_pkg;
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h04;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int SEL_BIT = 7;
  // register one field positions
  localparam int R1_LIMITER = 6;
  localparam int R1_CURRENT = 5;
  localparam int R1_TONE = 4;
  localparam int R1_COMP = 3;
  localparam int R1_HIGHV = 2;
  localparam int R1_ENABLE = 1;
  localparam int R1_OVERLOAD = 0;
  // register two field positions
  localparam int R2_CURRENT = 6;
  localparam int R2_TONE = 5;
  localparam int R2_COMP = 4;
  localparam int R2_HIGHV = 3;
  localparam int R2_ENABLE = 2;
  localparam int R2_OVERTEMP = 1;
  localparam int R2_OVERLOAD = 0;

  typedef enum logic [2:0] {
    LS_ADDR, LS_ADDR_ACK, LS_WDATA, LS_WACK, LS_RDATA, LS_RACK, LS_IGNORE
  } lnb_link_st_t;

  typedef enum logic [1:0] {FR_IDLE, FR_ARMED, FR_BUSY} lnb_frame_st_t;

  // asynchronous pin inputs, synchronised together
  typedef struct packed {
    logic scl;
    logic sda;
    logic power_ok;
    logic addr_sel;
    logic ch1_tone_mod;
    logic ch2_tone_mod;
    logic ch1_overload;
    logic ch2_overload;
    logic over_temp;
  } lnb_pins_t;

  // frozen for the whole frame so the link domain reads stable values
  typedef struct packed {
    logic power_ok;
    logic addr_sel;
    logic [7:0] image1;
    logic [7:0] image2;
  } lnb_cfg_t;

  typedef struct packed {
    logic boost_en;
    logic linreg_en;
    logic [1:0] level;
    logic tone;
    logic current_high;
  } lnb_chan_t;
endpackage
